// File: core/ptm_pkg.sv
// ptm_pkg: register map, field layout, modes and carrier types for the periodic timer
// assumes a 32-bit apb slave with word-aligned registers
package ptm_pkg;

  // register byte offsets
  localparam logic [7:0] CTRL_OFS   = 8'h00;
  localparam logic [7:0] CMPA_OFS   = 8'h04;
  localparam logic [7:0] PERIOD_OFS = 8'h08;
  localparam logic [7:0] STATUS_OFS = 8'h0c;
  localparam logic [7:0] COUNT_OFS  = 8'h10;

  // control field positions
  localparam int RUN_BIT    = 0;
  localparam int MODE_LO    = 1;
  localparam int PINF_LO    = 3;
  localparam int CCLR_BIT   = 5;
  localparam int OCL_BIT    = 6;
  localparam int POL_BIT    = 7;
  localparam int CAPTS_LO   = 8;
  localparam int WIDE_BIT   = 10;
  localparam int TICKSEL_LO = 11;

  // status field positions
  localparam int AF_BIT = 0;
  localparam int PF_BIT = 1;

  // reset values
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [15:0] CMP_RST  = 16'h0000;

  // counter limits
  localparam logic [15:0] MAX16 = 16'hffff;
  localparam logic [15:0] MAX10 = 16'h03ff;

  typedef enum logic [1:0] {
    MODE_COMPARE = 2'b00,
    MODE_CAPTURE = 2'b01,
    MODE_PWM     = 2'b10,
    MODE_TIMER   = 2'b11
  } ptm_mode_t;

  typedef enum logic [1:0] {
    PIN_LOW   = 2'b00,
    PIN_HIGH  = 2'b01,
    PIN_PWM   = 2'b10,
    PIN_PULSE = 2'b11
  } ptm_pinf_t;

  typedef struct packed {
    logic [4:0]  tick_sel;
    logic        wide;
    logic [1:0]  capt_src;
    logic        invert;
    logic        init_level;
    logic        clr_sel;
    ptm_pinf_t   pinf;
    ptm_mode_t   mode;
  } ptm_ctrl_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } ptm_apb_req_t;

endpackage : ptm_pkg

// File: core/ptm_timer.sv
// ptm_timer: periodic timer with pwm, single pulse and capture operation
// assumes pins synchronous to MCLK, software on an apb slave port
//
// Contract
// - wide variant: period zero gives 65535 counts; a-value sets duty.
// - narrow variant: period zero gives 1024 counts; a-value sets duty.
// - duty value at or above period keeps pwm output fully active.
// - period match clears the counter in pwm operation.
// - pwm counting continues while pin function forces a fixed level.
// - counter clear select ignored in pwm operation.
// - run rising edge starts counter and drives pulse leading edge.
// - trigger pin active edge sets run automatically in single pulse.
// - a-match or software clearing run ends the single pulse.
// - a-match raises interrupt flag in single pulse.
// - single pulse counter zeroed at run rise, else wraps at width; period ignored.
// - mode 01 is capture; source chosen among pin a, pin b, trigger pin.
// - pin function picks rising, falling, both; 11 disables capture only.
// - capture edge copies counter into a-value and raises flag.
// - capture counter runs while run set; period match clears, flags.
// - capture with period zero counts to 1023 narrow, 65534 wide.
// - capture watches selected pin even when it is driven as output.
// - clear select, initial level and invert ignored in capture.
// - pwm sets separate flags on a-match and period match.
// - invert flips pwm waveform; initial level picks base polarity.
module ptm_timer (
  // clock and reset
  input  wire logic        MCLK,
  input  wire logic        RESET,
  // apb slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  // pins
  input  wire logic        TIMER_PIN_A,
  input  wire logic        TIMER_PIN_B,
  input  wire logic        EXT_CLOCK_TRIGGER_PIN,
  output logic             TIMER_OUT,
  output logic             TIMER_IRQ
);

  ptm_pkg::ptm_apb_req_t req;
  ptm_pkg::ptm_ctrl_t    ctrl_q;
  logic        run_control_q;
  logic [15:0] compare_a_value_q;
  logic [15:0] period_compare_value_q;
  logic [15:0] count_q;
  logic [4:0]  tick_div_q;
  logic        af_q;
  logic        pf_q;
  logic        pa_q;
  logic        pb_q;
  logic        tck_q;
  logic        run_prev_q;
  logic        out_q;
  logic [31:0] prdata_q;
  logic        pready_q;
  logic        pslverr_q;

  assign req = '{psel: PSEL, penable: PENABLE, pwrite: PWRITE, paddr: PADDR, pwdata: PWDATA};

  // address decode, used by write and read paths
  function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] ofs);
    addr_hit = (a == ofs);
  endfunction : addr_hit

  function automatic logic mapped(input logic [7:0] a);
    mapped = addr_hit(a, ptm_pkg::CTRL_OFS) || addr_hit(a, ptm_pkg::CMPA_OFS) ||
             addr_hit(a, ptm_pkg::PERIOD_OFS) || addr_hit(a, ptm_pkg::STATUS_OFS) ||
             addr_hit(a, ptm_pkg::COUNT_OFS);
  endfunction : mapped

  logic        setup;
  logic        wr_en;
  logic [15:0] cnt_max;
  logic [15:0] cmp_mask;
  logic        tick;
  logic        run_rise;
  logic        is_pwm;
  logic        is_pulse;
  logic        is_capture;
  logic        a_match;
  logic        p_match;
  logic        cap_pin;
  logic        cap_prev;
  logic        cap_edge;
  logic        trig_edge;
  logic        pwm_active;
  logic        pwm_level;
  logic [15:0] eff_period;
  logic        count_live;
  logic        active_level;
  logic        wr_ctrl;
  logic        wr_cmpa;
  logic        wr_period;
  logic        wr_status;
  logic        af_clr;
  logic        pf_clr;

  // zero-wait slave: answer in the cycle after setup
  assign setup   = req.psel && !req.penable;
  assign wr_en   = req.psel && req.penable && req.pwrite && PREADY;

  // register write strobes
  assign wr_ctrl   = wr_en && addr_hit(req.paddr, ptm_pkg::CTRL_OFS);
  assign wr_cmpa   = wr_en && addr_hit(req.paddr, ptm_pkg::CMPA_OFS);
  assign wr_period = wr_en && addr_hit(req.paddr, ptm_pkg::PERIOD_OFS);
  assign wr_status = wr_en && addr_hit(req.paddr, ptm_pkg::STATUS_OFS);
  assign af_clr    = wr_status && req.pwdata[ptm_pkg::AF_BIT];
  assign pf_clr    = wr_status && req.pwdata[ptm_pkg::PF_BIT];

  assign cnt_max  = ctrl_q.wide ? ptm_pkg::MAX16 : ptm_pkg::MAX10;
  assign cmp_mask = cnt_max;
  assign tick     = (tick_div_q == ctrl_q.tick_sel);
  assign run_rise = run_control_q && !run_prev_q;

  assign is_pwm     = (ctrl_q.mode == ptm_pkg::MODE_PWM) && (ctrl_q.pinf != ptm_pkg::PIN_PULSE);
  assign is_pulse   = (ctrl_q.mode == ptm_pkg::MODE_PWM) && (ctrl_q.pinf == ptm_pkg::PIN_PULSE);
  assign is_capture = (ctrl_q.mode == ptm_pkg::MODE_CAPTURE);

  assign eff_period = (period_compare_value_q == 16'h0000) ?
                      (ctrl_q.wide ? ptm_pkg::MAX16 : ptm_pkg::MAX10 + 16'h0001) :
                      period_compare_value_q;

  // stale count of the last run must not match in the restart cycle
  assign count_live = run_control_q && !run_rise && tick;
  assign a_match    = count_live && ((count_q + 16'h0001) == compare_a_value_q);
  assign p_match    = count_live && ((count_q + 16'h0001) >= eff_period);

  // capture source taken straight from the pin, output or not
  always_comb begin
    case (ctrl_q.capt_src)
      2'b00:   begin cap_pin = TIMER_PIN_A; cap_prev = pa_q; end
      2'b01:   begin cap_pin = TIMER_PIN_B; cap_prev = pb_q; end
      default: begin cap_pin = EXT_CLOCK_TRIGGER_PIN; cap_prev = tck_q; end
    endcase
  end

  // edge kind from pin function; 11 gives no capture
  always_comb begin
    case (ctrl_q.pinf)
      ptm_pkg::PIN_LOW:  cap_edge = cap_pin && !cap_prev;
      ptm_pkg::PIN_HIGH: cap_edge = !cap_pin && cap_prev;
      ptm_pkg::PIN_PWM:  cap_edge = cap_pin ^ cap_prev;
      default:           cap_edge = 1'b0;
    endcase
  end

  // rising edge on the trigger pin starts a pulse
  assign trig_edge = EXT_CLOCK_TRIGGER_PIN && !tck_q;

  // active until counter reaches a-value, full when a >= period
  assign pwm_active = (compare_a_value_q >= eff_period) || (count_q < compare_a_value_q);
  assign active_level = ctrl_q.init_level ^ ctrl_q.invert;
  assign pwm_level    = pwm_active ? active_level : !active_level;

  // pin history
  always_ff @(posedge MCLK) begin
    if (RESET) begin
      pa_q  <= 1'b0;
      pb_q  <= 1'b0;
      tck_q <= 1'b0;
    end else begin
      pa_q  <= TIMER_PIN_A;
      pb_q  <= TIMER_PIN_B;
      tck_q <= EXT_CLOCK_TRIGGER_PIN;
    end
  end

  // control register
  always_ff @(posedge MCLK) begin
    if (RESET) begin
      ctrl_q <= ptm_pkg::ptm_ctrl_t'(ptm_pkg::CTRL_RST[15:1]);
    end else if (wr_ctrl) begin
      ctrl_q <= ptm_pkg::ptm_ctrl_t'(req.pwdata[15:1]);
    end
  end

  // run bit: hardware set and clear win over software
  always_ff @(posedge MCLK) begin
    if (RESET) begin
      run_control_q <= 1'b0;
    end else if (is_pulse && a_match) begin
      run_control_q <= 1'b0;
    end else if (is_pulse && trig_edge) begin
      run_control_q <= 1'b1;
    end else if (wr_ctrl) begin
      run_control_q <= req.pwdata[ptm_pkg::RUN_BIT];
    end
  end

  always_ff @(posedge MCLK) begin
    if (RESET) begin
      run_prev_q <= 1'b0;
    end else begin
      run_prev_q <= run_control_q;
    end
  end

  // tick prescaler: one tick every tick_sel+1 clocks
  always_ff @(posedge MCLK) begin
    if (RESET || tick) begin
      tick_div_q <= 5'h00;
    end else begin
      tick_div_q <= tick_div_q + 5'h01;
    end
  end

  // counter
  always_ff @(posedge MCLK) begin
    if (RESET) begin
      count_q <= 16'h0000;
    end else if (run_rise) begin
      count_q <= 16'h0000;
    end else if (run_control_q && tick) begin
      // period match clears, clear select not consulted
      if ((is_pwm || is_capture) && p_match) begin
        count_q <= 16'h0000;
      end else if (ctrl_q.mode == ptm_pkg::MODE_COMPARE || ctrl_q.mode == ptm_pkg::MODE_TIMER) begin
        count_q <= p_match ? 16'h0000 : (count_q + 16'h0001) & cnt_max;
      end else begin
        // one step per tick, wraps at width
        count_q <= (count_q + 16'h0001) & cnt_max;
      end
    end
  end

  // a-value: software write or capture
  always_ff @(posedge MCLK) begin
    if (RESET) begin
      compare_a_value_q <= ptm_pkg::CMP_RST;
    end else if (is_capture && run_control_q && cap_edge) begin
      compare_a_value_q <= count_q;
    end else if (wr_cmpa) begin
      compare_a_value_q <= req.pwdata[15:0] & cmp_mask;
    end
  end

  always_ff @(posedge MCLK) begin
    if (RESET) begin
      period_compare_value_q <= ptm_pkg::CMP_RST;
    end else if (wr_period) begin
      period_compare_value_q <= req.pwdata[15:0] & cmp_mask;
    end
  end

  // request flags; write one to clear, set wins
  always_ff @(posedge MCLK) begin
    if (RESET) begin
      af_q <= 1'b0;
    end else if ((!is_capture && a_match) || (is_capture && run_control_q && cap_edge)) begin
      af_q <= 1'b1;
    end else if (af_clr) begin
      af_q <= 1'b0;
    end
  end

  always_ff @(posedge MCLK) begin
    if (RESET) begin
      pf_q <= 1'b0;
    // period match flag, not in single pulse
    end else if (p_match && !is_pulse) begin
      pf_q <= 1'b1;
    end else if (pf_clr) begin
      pf_q <= 1'b0;
    end
  end

  always_ff @(posedge MCLK) begin
    if (RESET) begin
      TIMER_IRQ <= 1'b0;
    end else begin
      TIMER_IRQ <= af_q || pf_q;
    end
  end

  // output pin
  always_ff @(posedge MCLK) begin
    if (RESET) begin
      out_q <= 1'b0;
    end else if (is_pulse) begin
      out_q <= run_control_q ^ ctrl_q.invert;
    end else if (ctrl_q.mode == ptm_pkg::MODE_PWM) begin
      case (ctrl_q.pinf)
        ptm_pkg::PIN_LOW:  out_q <= 1'b0;
        ptm_pkg::PIN_HIGH: out_q <= 1'b1;
        default:           out_q <= pwm_level;
      endcase
    end else begin
      out_q <= out_q;
    end
  end

  assign TIMER_OUT = out_q;

  // apb read and answer
  always_ff @(posedge MCLK) begin
    if (RESET) begin
      prdata_q  <= 32'h0000_0000;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q  <= setup;
      pslverr_q <= setup && !mapped(req.paddr);
      prdata_q  <= 32'h0000_0000;
      if (setup && !req.pwrite) begin
        case (req.paddr)
          ptm_pkg::CTRL_OFS:   prdata_q <= {16'h0000, ctrl_q, run_control_q};
          ptm_pkg::CMPA_OFS:   prdata_q <= {16'h0000, compare_a_value_q};
          ptm_pkg::PERIOD_OFS: prdata_q <= {16'h0000, period_compare_value_q};
          ptm_pkg::STATUS_OFS: prdata_q <= {30'h0, pf_q, af_q};
          ptm_pkg::COUNT_OFS:  prdata_q <= {16'h0000, count_q};
          default:             prdata_q <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign PRDATA  = prdata_q;
  assign PREADY  = pready_q;
  assign PSLVERR = pslverr_q;

endmodule : ptm_timer

// File: testbench/ptm_timer_chk.sv
// ptm_timer_chk: port-level checks of the periodic timer
// assumes binding onto ptm_timer, single clock, synchronous reset
module ptm_timer_chk (
  // clock and reset
  input wire logic        MCLK,
  input wire logic        RESET,
  // apb
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [7:0]  PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic        PREADY,
  input wire logic        PSLVERR,
  // pins
  input wire logic        TIMER_OUT,
  input wire logic        TIMER_IRQ
);
  ptm_pkg::ptm_ctrl_t ctrl_q;
  logic               mapped;

  assign mapped = PADDR inside {ptm_pkg::CTRL_OFS, ptm_pkg::CMPA_OFS, ptm_pkg::PERIOD_OFS,
                                ptm_pkg::STATUS_OFS, ptm_pkg::COUNT_OFS};

  // shadow of the last control write
  always_ff @(posedge MCLK) begin
    if (RESET)
      ctrl_q <= '0;
    else if (PSEL && PENABLE && PREADY && PWRITE && PADDR == ptm_pkg::CTRL_OFS)
      ctrl_q <= PWDATA[15:1];
  end

  default clocking @(posedge MCLK); endclocking
  default disable iff (RESET);

  sequence s_setup;
    PSEL && !PENABLE;
  endsequence
  sequence s_force(f);
    (ctrl_q.mode == ptm_pkg::MODE_PWM && ctrl_q.pinf == f)[*2];
  endsequence

  a_ready_setup: assert property (s_setup |=> PREADY && PENABLE)
    else $error("no ready after setup");
  a_ready_single: assert property (PREADY |=> !PREADY)
    else $error("ready longer than one cycle");
  a_ready_access: assert property (PREADY |-> PSEL && PENABLE)
    else $error("ready outside access");
  a_err_unmapped: assert property (PREADY && !mapped |-> PSLVERR)
    else $error("unmapped access without error");
  a_err_mapped: assert property (PREADY && mapped |-> !PSLVERR)
    else $error("error on mapped access");
  a_read_zero: assert property (PREADY && !PWRITE && !mapped |-> PRDATA == '0)
    else $error("unmapped read not zero");
  a_upper_zero: assert property (PREADY && !PWRITE |-> PRDATA[31:16] == '0)
    else $error("upper read bits set");
  a_force_low: assert property (s_force(ptm_pkg::PIN_LOW) |-> !TIMER_OUT)
    else $error("forced low output high");
  a_force_high: assert property (s_force(ptm_pkg::PIN_HIGH) |-> TIMER_OUT)
    else $error("forced high output low");
  a_reset_quiet: assert property (disable iff (1'b0) RESET |=> !TIMER_OUT && !TIMER_IRQ && !PREADY)
    else $error("outputs active after reset");
endmodule : ptm_timer_chk

bind ptm_timer ptm_timer_chk u_chk (.MCLK(MCLK), .RESET(RESET), .PSEL(PSEL), .PENABLE(PENABLE),
  .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
  .PSLVERR(PSLVERR), .TIMER_OUT(TIMER_OUT), .TIMER_IRQ(TIMER_IRQ));

// File: testbench/ptm_pins_model.sv
// ptm_pins_model: external source of pulses on the timer input pins
// assumes go is a one-cycle request raised after a clock edge
module ptm_pins_model (
  // clock
  input wire logic       clk,
  // request
  input wire logic       go,
  input wire logic [1:0] sel,
  input wire logic [7:0] len,
  // pins
  output logic           pin_a,
  output logic           pin_b,
  output logic           pin_trig
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] left_q = 8'h00;
  logic [1:0] sel_q  = 2'h0;

  always_ff @(posedge clk) begin
    if (go) begin
      left_q <= len;
      sel_q  <= sel;
    end else if (left_q != 8'h00)
      left_q <= left_q - 8'h01;
  end

  assign pin_a    = left_q != 8'h00 && sel_q == 2'h0;
  assign pin_b    = left_q != 8'h00 && sel_q == 2'h1;
  assign pin_trig = left_q != 8'h00 && sel_q[1];
endmodule : ptm_pins_model

// File: testbench/ptm_timer_test.sv
// ptm_timer_test: self-checking bench of the periodic timer
// assumes ptm_timer with apb port, pins model and bound checker
module ptm_timer_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic                  MCLK  = 1'b0;
  logic                  RESET = 1'b1;
  ptm_pkg::ptm_apb_req_t req   = '0;
  logic [31:0]           prdata, rd;
  logic                  pready, pslverr, err, pin_a, pin_b, pin_t, tout, tirq;
  logic                  go    = 1'b0;
  logic [1:0]            sel   = 2'h0;
  int                    bad_count = 0;
  int                    cmp_count = 0;
  int                    cycles    = 0;

  always #5 MCLK = ~MCLK;

  ptm_timer uut (.MCLK(MCLK), .RESET(RESET), .PSEL(req.psel), .PENABLE(req.penable),
    .PWRITE(req.pwrite), .PADDR(req.paddr), .PWDATA(req.pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .TIMER_PIN_A(pin_a), .TIMER_PIN_B(pin_b), .EXT_CLOCK_TRIGGER_PIN(pin_t),
    .TIMER_OUT(tout), .TIMER_IRQ(tirq));
  ptm_pins_model pins (.clk(MCLK), .go(go), .sel(sel), .len(8'h1e), .pin_a(pin_a), .pin_b(pin_b),
    .pin_trig(pin_t));

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : test_done

  always @(posedge MCLK) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      bad_count++;
      test_done();
    end
  end

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
    @(posedge MCLK);
    req.penable <= 1'b1;
    // no local limit: this wait ends on pready, or on the bench timeout
    do begin
      @(posedge MCLK);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    req <= '0;
    @(posedge MCLK);
  endtask : apb

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic measure(input int cyc, output int hi);
    hi = 0;
    repeat (cyc) begin
      @(posedge MCLK);
      hi += int'(tout === 1'b1);
    end
  endtask : measure

  task automatic pulse(input logic [1:0] s);
    sel <= s;
    go  <= 1'b1;
    @(posedge MCLK);
    go  <= 1'b0;
  endtask : pulse

  // x: clear select, initial level, invert, capture source, wide
  function automatic logic [31:0] ctrl(logic run, ptm_pkg::ptm_mode_t m, ptm_pkg::ptm_pinf_t f,
                                       logic [7:0] x);
    return 32'(run) | (32'(m) << ptm_pkg::MODE_LO) | (32'(f) << ptm_pkg::PINF_LO)
           | (32'(x[5:0]) << ptm_pkg::CCLR_BIT);
  endfunction : ctrl

  function automatic int exp_high(int a, int p, logic pos, int k);
    int act;
    act = (a >= p) ? p : a;
    return pos ? act * k : (p - act) * k;
  endfunction : exp_high

  task automatic stop_clear();
    apb(1'b1, ptm_pkg::CTRL_OFS, 32'h0);
    apb(1'b1, ptm_pkg::STATUS_OFS, 32'h3);
    apb(1'b0, ptm_pkg::STATUS_OFS, 32'h0);
    chk(rd, 32'h0);
    chk(32'(tirq), 32'h0);
  endtask : stop_clear

  initial begin
    int          p, a, hi, d;
    logic [7:0]  x;
    logic [31:0] c1;
    c1 = $urandom(32'h50e34a5a);
    repeat (8) @(posedge MCLK);
    RESET <= 1'b0;
    @(posedge MCLK);
    for (int i = 0; i < 6; i++) begin
      apb(1'b0, 8'(4 * i), 32'h0);
      chk(rd, 32'h0);
      chk(32'(err), 32'(i == 5));
    end
    $display("test registers done");
    for (int i = 0; i < 6; i++) begin
      p = 8 + $urandom_range(40);
      a = (i == 0) ? p + 3 : (i == 1) ? 0 : $urandom_range(p);
      x = 8'($urandom_range(63)) & 8'h27;
      apb(1'b1, ptm_pkg::PERIOD_OFS, 32'(p));
      apb(1'b1, ptm_pkg::CMPA_OFS, 32'(a));
      apb(1'b1, ptm_pkg::CTRL_OFS, ctrl(1'b1, ptm_pkg::MODE_PWM, ptm_pkg::PIN_PWM, x));
      repeat (2 * p) @(posedge MCLK);
      measure(4 * p, hi);
      chk(32'(hi), 32'(exp_high(a, p, x[1] ^ x[2], 4)));
      apb(1'b0, ptm_pkg::STATUS_OFS, 32'h0);
      chk(32'(rd[ptm_pkg::PF_BIT]), 32'h1);
      chk(32'(tirq), 32'h1);
      apb(1'b1, ptm_pkg::CTRL_OFS, ctrl(1'b1, ptm_pkg::MODE_PWM, ptm_pkg::ptm_pinf_t'(i % 2), x));
      apb(1'b0, ptm_pkg::COUNT_OFS, 32'h0);
      c1 = rd;
      apb(1'b0, ptm_pkg::COUNT_OFS, 32'h0);
      chk(32'(rd != c1), 32'h1);
      stop_clear();
    end
    apb(1'b1, ptm_pkg::PERIOD_OFS, 32'h0);
    apb(1'b1, ptm_pkg::CMPA_OFS, 32'd256);
    apb(1'b1, ptm_pkg::CTRL_OFS, ctrl(1'b1, ptm_pkg::MODE_PWM, ptm_pkg::PIN_PWM, 8'h02));
    repeat (1024) @(posedge MCLK);
    measure(2048, hi);
    chk(32'(hi), 32'(exp_high(256, 1024, 1'b1, 2)));
    stop_clear();
    $display("test pwm done");
    for (int i = 0; i < 3; i++) begin
      a = 4 + $urandom_range(20);
      apb(1'b1, ptm_pkg::CMPA_OFS, 32'(a));
      apb(1'b1, ptm_pkg::CTRL_OFS, ctrl(i == 0, ptm_pkg::MODE_PWM, ptm_pkg::PIN_PULSE, 8'h00));
      if (i != 0)
        pulse(2'h2);
      measure(a + 10, hi);
      // restart cycle zeroes the counter, so the pulse is one clock longer than a
      chk(32'(hi), 32'(a + 1));
      apb(1'b0, ptm_pkg::CTRL_OFS, 32'h0);
      chk(32'(rd[ptm_pkg::RUN_BIT]), 32'h0);
      apb(1'b0, ptm_pkg::STATUS_OFS, 32'h0);
      chk(32'(rd[ptm_pkg::AF_BIT]), 32'h1);
      stop_clear();
    end
    apb(1'b1, ptm_pkg::CMPA_OFS, 32'd200);
    apb(1'b1, ptm_pkg::CTRL_OFS, ctrl(1'b1, ptm_pkg::MODE_PWM, ptm_pkg::PIN_PULSE, 8'h00));
    repeat (10) @(posedge MCLK);
    apb(1'b1, ptm_pkg::CTRL_OFS, ctrl(1'b0, ptm_pkg::MODE_PWM, ptm_pkg::PIN_PULSE, 8'h00));
    measure(20, hi);
    chk(32'(hi), 32'h0);
    stop_clear();
    $display("test pulse done");
    for (int j = 0; j < 4; j++) begin
      x = 8'h20 | 8'((j % 3) << 3);
      // written while narrow, so kept within ten bits
      apb(1'b1, ptm_pkg::CMPA_OFS, 32'h0234);
      apb(1'b1, ptm_pkg::CTRL_OFS, ctrl(1'b1, ptm_pkg::MODE_CAPTURE, ptm_pkg::ptm_pinf_t'(j), x));
      apb(1'b0, ptm_pkg::COUNT_OFS, 32'h0);
      c1 = rd;
      pulse(2'(j % 3));
      repeat (40) @(posedge MCLK);
      apb(1'b0, ptm_pkg::CMPA_OFS, 32'h0);
      d = int'(rd) - int'(c1);
      if (j == 3)
        chk(rd, 32'h0234);
      else
        chk(32'(j == 0 ? (d > 0 && d < 16) : (d >= 30 && d < 46)), 32'h1);
      apb(1'b0, ptm_pkg::STATUS_OFS, 32'h0);
      chk(32'(rd[ptm_pkg::AF_BIT]), 32'(j != 3));
      stop_clear();
    end
    $display("test capture done");
    test_done();
  end
endmodule : ptm_timer_test
